// file: shared/awc_pkg.sv
// What this block does
// - result register is 16 bits, two bytes, fed by a 10-bit converter sample.
// - all-zeros means zero, all-ones means full scale; plain unsigned values.
// - writable 16-bit low limit used by the window comparator.
// - writable 16-bit high limit used by the same comparator.
// - each limit is a byte pair: low byte at base, high byte at base plus one.
// - while accumulating, only the finished total is compared, never single samples.
// - duty select zero gives a 50 percent converter clock, needed above 1.5 MHz.
// - duty select one, the reset value, gives 25 percent high, 75 percent low.
// - tuning register: bit 0 duty select resets to one, bits 2 to 1 writable, reset zero.
//
// package of constants, types and helpers for the converter result window block
// assumes classic wishbone with 32-bit data, registers in the low byte of each word
`default_nettype none

package awc_pkg;

  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_RES_L = 6'h10;
  localparam logic [5:0] IDX_RES_H = 6'h11;
  localparam logic [5:0] IDX_WLO_L = 6'h12;
  localparam logic [5:0] IDX_WLO_H = 6'h13;
  localparam logic [5:0] IDX_WHI_L = 6'h14;
  localparam logic [5:0] IDX_WHI_H = 6'h15;
  localparam logic [5:0] IDX_TUNE  = 6'h16;
  localparam logic [5:0] IDX_CTRL  = 6'h18;
  localparam logic [5:0] IDX_STAT  = 6'h19;

  // ==========================================================
  // field layouts and reset values
  localparam logic [15:0] THR_RST       = 16'h0000;
  localparam logic [15:0] RES_RST       = 16'h0000;
  localparam logic [7:0]  TUNE_RST      = 8'h01;
  localparam logic [7:0]  TUNE_MASK     = 8'h07;
  localparam int unsigned TUNE_DUTY_BIT = 0;
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [7:0]  CTRL_MASK     = 8'h3f;
  localparam int unsigned CTRL_ACC_LSB  = 0;
  localparam int unsigned CTRL_MODE_LSB = 3;
  localparam logic [2:0]  ACC_MAX_LOG   = 3'h6;
  localparam int unsigned STAT_HIT_BIT  = 0;
  localparam int unsigned SAMPLE_W      = 10;
  localparam int unsigned RES_W         = 16;

  // ==========================================================
  // converter clock timing
  localparam int unsigned SYS_PERIOD_NS  = 10;
  localparam int unsigned CONV_PERIOD_NS = 40;
  localparam int unsigned CONV_DIV_CYC   = CONV_PERIOD_NS / SYS_PERIOD_NS;
  localparam logic [1:0]  CONV_DIV_LAST  = 2'(CONV_DIV_CYC - 1);
  localparam logic [1:0]  CONV_HI_25     = 2'(CONV_DIV_CYC / 4);
  localparam logic [1:0]  CONV_HI_50     = 2'(CONV_DIV_CYC / 2);

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    AWC_WIN_OFF     = 3'h0,
    AWC_WIN_BELOW   = 3'h1,
    AWC_WIN_ABOVE   = 3'h2,
    AWC_WIN_INSIDE  = 3'h3,
    AWC_WIN_OUTSIDE = 3'h4
  } awc_win_mode_t;

  typedef enum logic [1:0] {
    AWC_ST_FIRST = 2'b01,
    AWC_ST_SUM   = 2'b10
  } awc_acc_st_t;

  // ==========================================================
  // helpers
  // window match, unsigned compare since zero is all-zeros
  function automatic logic awc_win_match(input logic [2:0] m, input logic [15:0] r,
                                         input logic [15:0] lo, input logic [15:0] hi);
    logic below;
    logic above;
    below = (r < lo);
    above = (r > hi);
    case (m)
      AWC_WIN_BELOW:   awc_win_match = below;
      AWC_WIN_ABOVE:   awc_win_match = above;
      AWC_WIN_INSIDE:  awc_win_match = !below && !above;
      AWC_WIN_OUTSIDE: awc_win_match = below || above;
      default:         awc_win_match = 1'b0;
    endcase
  endfunction

  // number of samples per total, log2 field clamped so 64 x 1023 still fits 16 bits
  function automatic logic [6:0] awc_acc_len(input logic [2:0] l2);
    logic [2:0] l;
    l = (l2 > ACC_MAX_LOG) ? ACC_MAX_LOG : l2;
    awc_acc_len = 7'(7'h01 << l);
  endfunction

endpackage

`default_nettype wire

// file: shared/awc_cmp_if.sv
// interface between the register core and the window comparator
// assumes both ends share clk_i; no clocking block
`timescale 1ns/1ps
`default_nettype none

interface awc_cmp_if;
  logic [15:0] result;
  logic [15:0] low_lim;
  logic [15:0] high_lim;
  logic [2:0]  mode;
  logic        stored;
  logic        hit;
  logic        below;
  logic        above;

  modport core (output result, output low_lim, output high_lim, output mode, output stored,
                input hit, input below, input above);
  modport cmp  (input result, input low_lim, input high_lim, input mode, input stored,
                output hit, output below, output above);
endinterface

`default_nettype wire

// file: hw/awc_clkgen.sv
// converter clock divider with selectable duty cycle
// assumes duty select comes from a register on the same clock
`timescale 1ns/1ps
`default_nettype none

module awc_clkgen (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic duty_sel_i,
  output logic      conv_clk_o
);
  logic [1:0] cnt_ff;
  logic       sel_ff;
  logic       clk_ff;
  logic [1:0] nxt_cnt;
  logic       nxt_sel;

  // ==========================================================
  // divider; duty is latched per period so no runt pulses on a change
  always_comb begin
    nxt_cnt = (cnt_ff == awc_pkg::CONV_DIV_LAST) ? 2'h0 : 2'(cnt_ff + 2'h1);
    nxt_sel = (cnt_ff == awc_pkg::CONV_DIV_LAST) ? duty_sel_i : sel_ff;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= awc_pkg::CONV_DIV_LAST;
      sel_ff <= awc_pkg::TUNE_RST[awc_pkg::TUNE_DUTY_BIT];
      clk_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      sel_ff <= nxt_sel;
      clk_ff <= nxt_cnt < (nxt_sel ? awc_pkg::CONV_HI_25 : awc_pkg::CONV_HI_50);
    end
  end

  assign conv_clk_o = clk_ff;

  // ==========================================================
  // checks
  sequence s_hi25;
    conv_clk_o ##1 !conv_clk_o [*3] ##1 conv_clk_o;
  endsequence

  sequence s_hi50;
    conv_clk_o [*2] ##1 !conv_clk_o [*2] ##1 conv_clk_o;
  endsequence

  property p_duty25;
    @(posedge clk_i) disable iff (rst_i)
    ($rose(conv_clk_o) && sel_ff && cnt_ff == 2'h0) |-> s_hi25;
  endproperty
  a_duty25: assert property (p_duty25) else $error("quarter duty period wrong");

  property p_duty50;
    @(posedge clk_i) disable iff (rst_i)
    ($rose(conv_clk_o) && !sel_ff && cnt_ff == 2'h0) |-> s_hi50;
  endproperty
  a_duty50: assert property (p_duty50) else $error("half duty period wrong");
endmodule

`default_nettype wire

// file: hw/awc_window.sv
// window comparator on stored results
// assumes stored pulses only when a new result or finished total is written
`timescale 1ns/1ps
`default_nettype none

module awc_window (
  input  wire logic clk_i,
  input  wire logic rst_i,
  awc_cmp_if.cmp    cmp
);
  logic hit_ff;
  logic below_ff;
  logic above_ff;

  // ==========================================================
  // evaluate once per stored value with the live limits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hit_ff   <= 1'b0;
      below_ff <= 1'b0;
      above_ff <= 1'b0;
    end else if (cmp.stored) begin
      hit_ff   <= awc_pkg::awc_win_match(cmp.mode, cmp.result, cmp.low_lim, cmp.high_lim);
      below_ff <= cmp.result < cmp.low_lim;
      above_ff <= cmp.result > cmp.high_lim;
    end else begin
      hit_ff   <= 1'b0;
    end
  end

  assign cmp.hit   = hit_ff;
  assign cmp.below = below_ff;
  assign cmp.above = above_ff;

  // ==========================================================
  // checks
  property p_eval;
    @(posedge clk_i) disable iff (rst_i)
    cmp.stored |=> (below_ff == $past(cmp.result < cmp.low_lim)) && (above_ff == $past(cmp.result > cmp.high_lim));
  endproperty
  a_eval: assert property (p_eval) else $error("limit levels not refreshed");

  property p_hit_only_on_store;
    @(posedge clk_i) disable iff (rst_i)
    !cmp.stored |=> !hit_ff;
  endproperty
  a_hit_only_on_store: assert property (p_hit_only_on_store) else $error("hit without new result");
endmodule

`default_nettype wire

// file: hw/awc_top.sv
// converter result register, accumulation and window limits behind a wishbone slave
// assumes sample_valid_i and sample_data_i come from logic on clk_i
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

module awc_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        sample_valid_i,
  input  wire logic [9:0]  sample_data_i,
  output logic             converter_clock_o,
  output logic             window_event_o
);

  // ==========================================================
  // declarations
  awc_cmp_if cmp_bus ();

  logic                  ack_ff;
  logic [31:0]           rdat_ff;
  logic [7:0]            nxt_rbyte;
  logic [15:0]           wlo_ff;
  logic [15:0]           whi_ff;
  logic [15:0]           res_ff;
  logic [15:0]           acc_ff;
  logic [7:0]            tune_ff;
  logic [7:0]            ctrl_ff;
  logic                  hit_ff;
  logic                  stored_ff;
  logic [6:0]            cnt_ff;
  awc_pkg::awc_acc_st_t  st_ff;
  logic                  req;
  logic                  wr_en;
  logic [5:0]            idx;
  logic                  ctrl_wr;
  logic [6:0]            acc_len;
  logic [15:0]           samp_ext;
  logic [15:0]           nxt_sum;
  logic [6:0]            nxt_cnt;
  logic                  store_now;

  // ==========================================================
  // bus decode
  // writes land on the ack edge, when the master is sure to sample ack
  assign req     = wb_cyc_i && wb_stb_i;
  assign idx     = wb_adr_i[7:2];
  assign wr_en   = req && wb_we_i && wb_sel_i[0] && ack_ff;
  assign ctrl_wr = wr_en && (idx == awc_pkg::IDX_CTRL);

  // one ack per request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req && !ack_ff;
    end
  end

  assign wb_ack_o = ack_ff;

  // read byte select; unmapped and reserved indices read zero
  always_comb begin
    case (idx)
      awc_pkg::IDX_RES_L: nxt_rbyte = res_ff[7:0];
      awc_pkg::IDX_RES_H: nxt_rbyte = res_ff[15:8];
      awc_pkg::IDX_WLO_L: nxt_rbyte = wlo_ff[7:0];
      awc_pkg::IDX_WLO_H: nxt_rbyte = wlo_ff[15:8];
      awc_pkg::IDX_WHI_L: nxt_rbyte = whi_ff[7:0];
      awc_pkg::IDX_WHI_H: nxt_rbyte = whi_ff[15:8];
      awc_pkg::IDX_TUNE:  nxt_rbyte = tune_ff;
      awc_pkg::IDX_CTRL:  nxt_rbyte = ctrl_ff;
      awc_pkg::IDX_STAT:  nxt_rbyte = {5'h00, cmp_bus.above, cmp_bus.below, hit_ff};
      default:            nxt_rbyte = 8'h00;
    endcase
  end

  // read data captured with ack so it stands while ack is high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_ff <= 32'h0000_0000;
    end else if (req && !ack_ff) begin
      rdat_ff <= {24'h00_0000, nxt_rbyte};
    end
  end

  assign wb_dat_o = rdat_ff;

  // ==========================================================
  // limit registers, each byte written on its own
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wlo_ff <= awc_pkg::THR_RST;
    end else if (wr_en && idx == awc_pkg::IDX_WLO_L) begin
      wlo_ff[7:0] <= wb_dat_i[7:0];
    end else if (wr_en && idx == awc_pkg::IDX_WLO_H) begin
      wlo_ff[15:8] <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      whi_ff <= awc_pkg::THR_RST;
    end else if (wr_en && idx == awc_pkg::IDX_WHI_L) begin
      whi_ff[7:0] <= wb_dat_i[7:0];
    end else if (wr_en && idx == awc_pkg::IDX_WHI_H) begin
      whi_ff[15:8] <= wb_dat_i[7:0];
    end
  end

  // ==========================================================
  // tuning and control
  // bits above 2 are not stored, so they read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tune_ff <= awc_pkg::TUNE_RST;
    end else if (wr_en && idx == awc_pkg::IDX_TUNE) begin
      tune_ff <= wb_dat_i[7:0] & awc_pkg::TUNE_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= awc_pkg::CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_ff <= wb_dat_i[7:0] & awc_pkg::CTRL_MASK;
    end
  end

  // ==========================================================
  // accumulation
  // a control write restarts the group; a partial total is dropped, not stored
  assign acc_len  = awc_pkg::awc_acc_len(ctrl_ff[awc_pkg::CTRL_ACC_LSB +: 3]);
  assign samp_ext = {6'h00, sample_data_i};
  assign nxt_sum  = 16'(acc_ff + samp_ext);
  assign nxt_cnt  = 7'(cnt_ff + 7'h01);
  assign store_now = sample_valid_i && !ctrl_wr &&
                     (((st_ff == awc_pkg::AWC_ST_FIRST) && (acc_len == 7'h01)) ||
                      ((st_ff == awc_pkg::AWC_ST_SUM) && (nxt_cnt == acc_len)));

  always_ff @(posedge clk_i) begin
    if (rst_i || ctrl_wr) begin
      st_ff  <= awc_pkg::AWC_ST_FIRST;
      acc_ff <= 16'h0000;
      cnt_ff <= 7'h00;
    end else begin
      case (st_ff)
        awc_pkg::AWC_ST_FIRST: begin
          if (sample_valid_i && acc_len != 7'h01) begin
            acc_ff <= samp_ext;
            cnt_ff <= 7'h01;
            st_ff  <= awc_pkg::AWC_ST_SUM;
          end
        end
        awc_pkg::AWC_ST_SUM: begin
          if (sample_valid_i) begin
            acc_ff <= nxt_sum;
            cnt_ff <= nxt_cnt;
            if (nxt_cnt == acc_len) begin
              st_ff <= awc_pkg::AWC_ST_FIRST;
            end
          end
        end
        default: begin
          st_ff <= awc_pkg::AWC_ST_FIRST;
        end
      endcase
    end
  end

  // result register and its one-cycle stored strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_ff    <= awc_pkg::RES_RST;
      stored_ff <= 1'b0;
    end else begin
      stored_ff <= store_now;
      if (store_now) begin
        res_ff <= (st_ff == awc_pkg::AWC_ST_FIRST) ? samp_ext : nxt_sum;
      end
    end
  end

  // ==========================================================
  // comparator hookup and sticky hit flag
  assign cmp_bus.result   = res_ff;
  assign cmp_bus.low_lim  = wlo_ff;
  assign cmp_bus.high_lim = whi_ff;
  assign cmp_bus.mode     = ctrl_ff[awc_pkg::CTRL_MODE_LSB +: 3];
  assign cmp_bus.stored   = stored_ff;

  awc_window u_window (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cmp   (cmp_bus)
  );

  // write one to clear; a hit in the same cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hit_ff <= 1'b0;
    end else if (cmp_bus.hit) begin
      hit_ff <= 1'b1;
    end else if (wr_en && idx == awc_pkg::IDX_STAT && wb_dat_i[awc_pkg::STAT_HIT_BIT]) begin
      hit_ff <= 1'b0;
    end
  end

  assign window_event_o = cmp_bus.hit;

  // ==========================================================
  // converter clock
  awc_clkgen u_clkgen (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .duty_sel_i (tune_ff[awc_pkg::TUNE_DUTY_BIT]),
    .conv_clk_o (converter_clock_o)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_req_new;
    req && !ack_ff;
  endsequence

  property p_ack;
    s_req_new |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle after request");

  property p_tune_reset;
    $fell(rst_i) |-> (tune_ff == 8'h01) && (converter_clock_o == 1'b0);
  endproperty
  a_tune_reset: assert property (p_tune_reset) else $error("tuning reset value wrong");

  property p_tune_reserved;
    tune_ff[7:3] == 5'h00;
  endproperty
  a_tune_reserved: assert property (p_tune_reserved) else $error("tuning reserved bits set");

  property p_wlo_byte;
    (wr_en && idx == awc_pkg::IDX_WLO_L) |=>
      (wlo_ff[7:0] == $past(wb_dat_i[7:0])) && (wlo_ff[15:8] == $past(wlo_ff[15:8]));
  endproperty
  a_wlo_byte: assert property (p_wlo_byte) else $error("low limit low byte write wrong");

  property p_whi_byte;
    (wr_en && idx == awc_pkg::IDX_WHI_H) |=>
      (whi_ff[15:8] == $past(wb_dat_i[7:0])) && (whi_ff[7:0] == $past(whi_ff[7:0]));
  endproperty
  a_whi_byte: assert property (p_whi_byte) else $error("high limit high byte write wrong");

  property p_single_store;
    (sample_valid_i && !ctrl_wr && st_ff == awc_pkg::AWC_ST_FIRST && acc_len == 7'h01) |=>
      stored_ff && (res_ff == {6'h00, $past(sample_data_i)});
  endproperty
  a_single_store: assert property (p_single_store) else $error("single sample not stored");

  property p_no_partial;
    (sample_valid_i && st_ff == awc_pkg::AWC_ST_SUM && nxt_cnt != acc_len) |=> !stored_ff;
  endproperty
  a_no_partial: assert property (p_no_partial) else $error("partial total reached comparator");

  property p_hit_sticky;
    cmp_bus.hit |=> hit_ff;
  endproperty
  a_hit_sticky: assert property (p_hit_sticky) else $error("hit flag lost");

  property p_store_to_event;
    stored_ff && (awc_pkg::awc_win_match(cmp_bus.mode, res_ff, wlo_ff, whi_ff)) |=> window_event_o;
  endproperty
  a_store_to_event: assert property (p_store_to_event) else $error("window match missed");

endmodule

`default_nettype wire

// file: dv/awc_top_tb.sv
// testbench for the converter result window block: registers, samples, window, clock
// assumes awc_top with classic wishbone, registers in the low byte of each word
`timescale 1ns/1ps
`default_nettype none

module awc_top_tb;
  // ==========================================================
  // signals
  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        sample_valid_i;
  logic [9:0]  sample_data_i;
  logic        converter_clock_o;
  logic        window_event_o;
  int          n_mismatch;
  int          cmp_count;
  int          ev_cnt;
  logic [31:0] rd;

  awc_top dut (
    .clk_i             (clk_i),
    .rst_i             (rst_i),
    .wb_cyc_i          (wb_cyc_i),
    .wb_stb_i          (wb_stb_i),
    .wb_we_i           (wb_we_i),
    .wb_adr_i          (wb_adr_i),
    .wb_sel_i          (wb_sel_i),
    .wb_dat_i          (wb_dat_i),
    .wb_dat_o          (wb_dat_o),
    .wb_ack_o          (wb_ack_o),
    .sample_valid_i    (sample_valid_i),
    .sample_data_i     (sample_data_i),
    .converter_clock_o (converter_clock_o),
    .window_event_o    (window_event_o)
  );

  // ==========================================================
  // clock, 100 MHz
  initial clk_i = 1'b0;
  always #5 clk_i = ~clk_i;

  // event pulses counted here so no scenario misses a one-cycle pulse
  always @(posedge clk_i) begin
    if (window_event_o === 1'b1) begin
      ev_cnt++;
    end
  end

  // ==========================================================
  // helpers
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one classic cycle; the request is held until ack is sampled high at an edge
  task automatic wb_xfer(input logic we, input logic [5:0] idx, input logic [7:0] d, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h000000, d};
    // no cycle limit here: a missing ack is left to the watchdog
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    // ack must last one cycle; looked at one edge after it was seen
    @(posedge clk_i);
    chk("bus ack drop", 32'h00000000, {31'h0, wb_ack_o});
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] q;
    wb_xfer(1'b1, idx, d, q);
  endtask

  task automatic rd8(input logic [5:0] idx, output logic [31:0] q);
    wb_xfer(1'b0, idx, 8'h00, q);
  endtask

  // n back-to-back samples of one value, then time for result and event
  task automatic samples(input logic [9:0] v, input int n);
    ev_cnt = 0;
    @(posedge clk_i);
    sample_valid_i <= 1'b1;
    sample_data_i  <= v;
    repeat (n) @(posedge clk_i);
    sample_valid_i <= 1'b0;
    sample_data_i  <= ~v;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic chk_result(input logic [15:0] exp);
    logic [31:0] lo;
    logic [31:0] hi;
    rd8(awc_pkg::IDX_RES_L, lo);
    rd8(awc_pkg::IDX_RES_H, hi);
    chk("result", {16'h0000, exp}, {16'h0000, hi[7:0], lo[7:0]});
  endtask

  // window outcome worked out here, equal to a limit counts as inside
  function automatic logic win_exp(input int m, input int r, input int lo, input int hi);
    case (m)
      1: win_exp = r < lo;
      2: win_exp = r > hi;
      3: win_exp = r >= lo && r <= hi;
      4: win_exp = r < lo || r > hi;
      default: win_exp = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // scenarios
  task automatic t_reset_values();
    rd8(awc_pkg::IDX_WLO_L, rd); chk("low limit L", 32'h0, rd);
    rd8(awc_pkg::IDX_WLO_H, rd); chk("low limit H", 32'h0, rd);
    rd8(awc_pkg::IDX_WHI_L, rd); chk("high limit L", 32'h0, rd);
    rd8(awc_pkg::IDX_WHI_H, rd); chk("high limit H", 32'h0, rd);
    rd8(awc_pkg::IDX_TUNE, rd);  chk("tuning", 32'h1, rd);
    chk_result(16'h0000);
    rd8(6'h1f, rd);              chk("unmapped", 32'h0, rd);
  endtask

  task automatic t_byte_pairs();
    wr(awc_pkg::IDX_WLO_L, 8'h34);
    wr(awc_pkg::IDX_WLO_H, 8'h12);
    wr(awc_pkg::IDX_WHI_L, 8'hcd);
    wr(awc_pkg::IDX_WHI_H, 8'hab);
    rd8(awc_pkg::IDX_WLO_L, rd); chk("low limit L", 32'h34, rd);
    rd8(awc_pkg::IDX_WLO_H, rd); chk("low limit H", 32'h12, rd);
    rd8(awc_pkg::IDX_WHI_L, rd); chk("high limit L", 32'hcd, rd);
    rd8(awc_pkg::IDX_WHI_H, rd); chk("high limit H", 32'hab, rd);
    wr(awc_pkg::IDX_TUNE, 8'hfe);
    rd8(awc_pkg::IDX_TUNE, rd);  chk("tuning", 32'h06, rd);
    wr(awc_pkg::IDX_RES_L, 8'h55);
    chk_result(16'h0000);
  endtask

  // full scale and zero pass through unchanged
  task automatic t_result_range();
    wr(awc_pkg::IDX_CTRL, 8'h00);
    samples(10'h3ff, 1); chk_result(16'h03ff);
    samples(10'h000, 1); chk_result(16'h0000);
  endtask

  // four samples each below the low limit; only their total is judged
  task automatic t_accumulate();
    wr(awc_pkg::IDX_WLO_L, 8'h00);
    wr(awc_pkg::IDX_WLO_H, 8'h01);
    wr(awc_pkg::IDX_WHI_L, 8'h00);
    wr(awc_pkg::IDX_WHI_H, 8'h01);
    wr(awc_pkg::IDX_CTRL, 8'h0a);
    samples(10'h050, 4);
    chk_result(16'h0140);
    chk("below events", 32'h0, 32'(ev_cnt));
    wr(awc_pkg::IDX_CTRL, 8'h12);
    samples(10'h050, 4);
    chk("above events", 32'h1, 32'(ev_cnt));
    // log2 field 7 is clamped to 64 samples; largest total still fits
    wr(awc_pkg::IDX_CTRL, 8'h07);
    samples(10'h3ff, 64);
    chk_result(16'hffc0);
  endtask

  // every mode against values around both limits, then a limit moved
  task automatic t_modes();
    int vals[4] = '{'h050, 'h100, 'h150, 'h250};
    wr(awc_pkg::IDX_WHI_H, 8'h02);
    for (int m = 0; m < 5; m++) begin
      wr(awc_pkg::IDX_CTRL, 8'(m << 3));
      foreach (vals[i]) begin
        samples(10'(vals[i]), 1);
        chk("window event", 32'(win_exp(m, vals[i], 'h100, 'h200)), 32'(ev_cnt));
      end
    end
    wr(awc_pkg::IDX_WHI_H, 8'h01);
    wr(awc_pkg::IDX_WHI_L, 8'h20);
    samples(10'h150, 1);
    chk("moved limit", 32'h1, 32'(ev_cnt));
    // status: sticky hit, not below, above; write one clears only the hit
    rd8(awc_pkg::IDX_STAT, rd);  chk("status after hit", 32'h05, rd);
    wr(awc_pkg::IDX_STAT, 8'h01);
    rd8(awc_pkg::IDX_STAT, rd);  chk("status cleared", 32'h04, rd);
  endtask

  // high cycles over two converter periods of four system cycles
  task automatic t_duty(input logic [7:0] tune, input int exp_hi);
    int hi;
    hi = 0;
    wr(awc_pkg::IDX_TUNE, tune);
    repeat (8) @(posedge clk_i);
    repeat (8) begin
      @(posedge clk_i);
      if (converter_clock_o === 1'b1) begin
        hi++;
      end
    end
    chk("clock high cycles", 32'(exp_hi), 32'(hi));
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    sample_valid_i = 1'b0;
    sample_data_i = 10'h000;
    n_mismatch = 0;
    cmp_count = 0;
    ev_cnt = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_values();
    t_duty(8'h01, 2);
    t_byte_pairs();
    t_duty(8'h00, 4);
    t_result_range();
    t_accumulate();
    t_modes();
    print_verdict();
  end

  // the run needs about five hundred cycles; the 20000-cycle limit is a generous margin
  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
endmodule

`default_nettype wire
